// [hw/frl_pkg.sv]
package frl_pkg;

	// register offsets
	localparam logic [7:0] FRL_CAUSE_OFS  = 8'hea;
	localparam logic [7:0] FRL_PREV_OFS   = 8'heb;
	localparam logic [7:0] FRL_SNAP1_OFS  = 8'hec;
	localparam logic [7:0] FRL_SNAP2_OFS  = 8'hed;
	localparam logic [7:0] FRL_SNAP3_OFS  = 8'hee;
	localparam logic [7:0] FRL_SNAP4_OFS  = 8'hef;
	localparam logic [7:0] FRL_SNAP5_OFS  = 8'he9;
	localparam logic [7:0] FRL_TRIG_OFS   = 8'hf0;
	localparam logic [7:0] FRL_STATUS_OFS = 8'hf8;

	// field positions
	localparam int FRL_INUSE_BIT = 7;
	localparam int FRL_PEER_BIT  = 6;
	localparam int FRL_JUMP_BIT  = 5;
	localparam int FRL_WARN_BIT  = 4;
	localparam int FRL_SFD_BIT   = 3;
	localparam int FRL_PREV_W    = 6;

	// nonvolatile record layout
	localparam logic [15:0] FRL_NV_BASE   = 16'hf980;
	localparam int          FRL_REC_BYTES = 8;
	localparam logic [7:0]  FRL_RST_BYTE  = 8'h00;

	// live monitor inputs and transition cause from the sequencer
	typedef struct packed {
		logic [9:0] uv;
		logic [9:0] ov;
		logic [9:0] lim;
		logic [4:0] gpi;
	} frl_flags_s;

	typedef struct packed {
		logic       peer_msg;
		logic       host_jump;
		logic       conv_warn;
		logic       sfd_trip;
		logic       timeout;
		logic       monitor;
		logic       seq_cond;
	} frl_cause_s;

	typedef enum logic [2:0] {
		FRL_SCAN_RD,
		FRL_SCAN_WAIT,
		FRL_SCAN_CHK,
		FRL_IDLE,
		FRL_WR,
		FRL_WR_WAIT
	} frl_fsm_e;

endpackage

// [hw/frl_logger.sv]
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module frl_logger
	import frl_pkg::*;
#(
	parameter int SLOTS = 16,
	parameter int STATES = 64
) (
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	// sequencer side
	input  wire logic                  SEQ_CHANGE,
	input  wire logic [FRL_PREV_W-1:0] SEQ_NEW_STATE,
	input  wire logic [FRL_PREV_W-1:0] SEQ_PREV_STATE,
	input  wire frl_cause_s            SEQ_CAUSE,
	input  wire frl_flags_s            LIVE_FLAGS,
	// register port
	input  wire logic [7:0]            REG_ADDR,
	input  wire logic [7:0]            REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic      [7:0]            REG_RDATA,
	// nonvolatile memory port
	output logic      [15:0]           NV_ADDR,
	output logic      [7:0]            NV_WDATA,
	output logic                       NV_WR,
	output logic                       NV_RD,
	input  wire logic [7:0]            NV_RDATA,
	input  wire logic                  NV_BUSY,
	output logic                       LOG_BUSY,
	output logic                       LOG_FULL
);

	localparam int SW = $clog2(SLOTS);

	typedef struct packed {
		frl_fsm_e              fsm;
		logic [6:0][7:0]       snap;
		logic [6:0][7:0]       rec;
		logic [7:0]            sum;
		logic [2:0]            idx;
		logic [SW-1:0]         slot;
		logic                  full;
		logic                  pend;
		logic [STATES-1:0]     trig;
		logic [7:0]            rdata;
		logic [15:0]           nv_addr;
		logic [7:0]            nv_wdata;
		logic                  nv_wr;
		logic                  nv_rd;
	} frl_state_s;

	frl_state_s st;
	frl_state_s next_st;
	logic [6:0][7:0] fresh;
	logic [15:0] slot_base;
	logic [7:0] wr_byte;

	////////////////////////////////////////////////////////////////////////
	// snapshot assembly from live flags and cause
	always_comb begin
		fresh[0] = {1'b0,
			SEQ_CAUSE.peer_msg,
			SEQ_CAUSE.host_jump,
			SEQ_CAUSE.conv_warn,
			SEQ_CAUSE.sfd_trip,
			SEQ_CAUSE.timeout,
			SEQ_CAUSE.monitor,
			SEQ_CAUSE.seq_cond};
		fresh[1] = {2'h0, SEQ_PREV_STATE};
		fresh[2] = LIVE_FLAGS.uv[7:0];
		fresh[3] = {LIVE_FLAGS.ov[5:0], LIVE_FLAGS.uv[9:8]};
		fresh[4] = {LIVE_FLAGS.gpi[3:0], LIVE_FLAGS.ov[9:6]};
		fresh[5] = LIVE_FLAGS.lim[7:0];
		fresh[6] = {3'h0, LIVE_FLAGS.gpi[4], 2'h0, LIVE_FLAGS.lim[9:8]};
	end

	// slot base address and the byte being written
	always_comb begin
		slot_base = FRL_NV_BASE + {st.slot, 3'h0};
		if (st.idx == 3'h7) begin
			wr_byte = st.sum;
		end else begin
			wr_byte = st.rec[st.idx];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_st = st;
		next_st.nv_wr = 1'b0;
		next_st.nv_rd = 1'b0;

		// register reads return one cycle later; reserved reads as zero
		if (REG_RD) begin
			if (REG_ADDR == FRL_CAUSE_OFS) begin
				next_st.rdata = st.snap[0];
			end else if (REG_ADDR == FRL_PREV_OFS) begin
				next_st.rdata = st.snap[1];
			end else if (REG_ADDR == FRL_SNAP1_OFS) begin
				next_st.rdata = st.snap[2];
			end else if (REG_ADDR == FRL_SNAP2_OFS) begin
				next_st.rdata = st.snap[3];
			end else if (REG_ADDR == FRL_SNAP3_OFS) begin
				next_st.rdata = st.snap[4];
			end else if (REG_ADDR == FRL_SNAP4_OFS) begin
				next_st.rdata = st.snap[5];
			end else if (REG_ADDR == FRL_SNAP5_OFS) begin
				next_st.rdata = st.snap[6];
			end else if (REG_ADDR[7:3] == FRL_TRIG_OFS[7:3]) begin
				next_st.rdata = st.trig[REG_ADDR[2:0]*8 +: 8];
			end else if (REG_ADDR == FRL_STATUS_OFS) begin
				next_st.rdata = {6'h0, st.full, st.fsm != FRL_IDLE};
			end else begin
				next_st.rdata = FRL_RST_BYTE;
			end
		end

		// trigger bits, one byte per eight states
		if (REG_WR && REG_ADDR[7:3] == FRL_TRIG_OFS[7:3]) begin
			next_st.trig[REG_ADDR[2:0]*8 +: 8] = REG_WDATA;
		end

		// every change refreshes the snapshot registers
		if (SEQ_CHANGE) begin
			next_st.snap = fresh;
			if (st.trig[SEQ_NEW_STATE]) begin
				next_st.pend = 1'b1;
			end
		end

		case (st.fsm)
			// look for the first slot whose in-use bit is clear
			FRL_SCAN_RD: begin
				if (!NV_BUSY) begin
					next_st.nv_rd = 1'b1;
					next_st.nv_addr = slot_base;
					next_st.fsm = FRL_SCAN_WAIT;
				end
			end
			FRL_SCAN_WAIT: begin
				next_st.fsm = FRL_SCAN_CHK;
			end
			FRL_SCAN_CHK: begin
				if (NV_RDATA[FRL_INUSE_BIT]) begin
					if (st.slot == SW'(SLOTS - 1)) begin
						next_st.full = 1'b1;
						next_st.fsm = FRL_IDLE;
					end else begin
						next_st.slot = st.slot + 1'b1;
						next_st.fsm = FRL_SCAN_RD;
					end
				end else begin
					next_st.fsm = FRL_IDLE;
				end
			end
			// a record is copied so later changes cannot tear it
			FRL_IDLE: begin
				if (st.pend && !st.full) begin
					next_st.pend = SEQ_CHANGE && st.trig[SEQ_NEW_STATE];
					next_st.rec = st.snap;
					next_st.rec[0][FRL_INUSE_BIT] = 1'b1;
					next_st.idx = 3'h0;
					next_st.sum = 8'h00;
					next_st.fsm = FRL_WR;
				end else if (st.full) begin
					next_st.pend = 1'b0;
				end
			end
			// one byte per memory write, waiting out the busy flag
			FRL_WR: begin
				if (!NV_BUSY) begin
					next_st.nv_wr = 1'b1;
					next_st.nv_addr = slot_base + {13'h0, st.idx};
					next_st.nv_wdata = wr_byte;
					next_st.sum = st.sum + wr_byte;
					next_st.fsm = FRL_WR_WAIT;
				end
			end
			// one idle cycle lets the memory raise busy
			FRL_WR_WAIT: begin
				if (st.idx == 3'h7) begin
					if (st.slot == SW'(SLOTS - 1)) begin
						next_st.full = 1'b1;
					end else begin
						next_st.slot = st.slot + 1'b1;
					end
					next_st.fsm = FRL_IDLE;
				end else begin
					next_st.idx = st.idx + 3'h1;
					next_st.fsm = FRL_WR;
				end
			end
			default: begin
				next_st.fsm = FRL_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register; a scan starts at every reset
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			st <= '0;
			st.fsm <= FRL_SCAN_RD;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops, except LOG_BUSY, which is decoded from the state
	assign REG_RDATA = st.rdata;
	assign NV_ADDR   = st.nv_addr;
	assign NV_WDATA  = st.nv_wdata;
	assign NV_WR     = st.nv_wr;
	assign NV_RD     = st.nv_rd;
	assign LOG_BUSY  = st.fsm != FRL_IDLE;
	assign LOG_FULL  = st.full;

endmodule

// [testbench/frl_logger_sva.sv]
`timescale 1ns/1ps
module frl_logger_chk
	import frl_pkg::*;
#(
	parameter int SLOTS = 16
) (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic [7:0]  REG_ADDR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_RDATA,
	input wire logic [15:0] NV_ADDR,
	input wire logic [7:0]  NV_WDATA,
	input wire logic        NV_WR,
	input wire logic        NV_RD
);
	logic [15:0] last_addr;
	logic [7:0]  sum;
	// running record sum, restarted at a slot base so a torn record cannot leak into the next
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			last_addr <= 16'h0000;
			sum <= 8'h00;
		end else if (NV_WR) begin
			last_addr <= NV_ADDR;
			sum <= (NV_ADDR[2:0] == 3'h0) ? NV_WDATA : sum + NV_WDATA;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	sequence s_cause_rd;
		REG_RD && (REG_ADDR == FRL_CAUSE_OFS);
	endsequence
	sequence s_rec_byte;
		NV_WR && (NV_ADDR[2:0] != 3'h0);
	endsequence
	chk_cause_msb: assert property (s_cause_rd |=> REG_RDATA[7] == 1'b0)
		else $error("cause bit 7 read as one");
	chk_prev_width: assert property (REG_RD && REG_ADDR == FRL_PREV_OFS |=> REG_RDATA[7:6] == 2'h0)
		else $error("prior state wider than six bits");
	chk_nv_window: assert property (NV_WR |-> NV_ADDR >= FRL_NV_BASE
		&& NV_ADDR < FRL_NV_BASE + 16'(FRL_REC_BYTES * SLOTS)) else $error("write outside region");
	chk_wr_gap: assert property (NV_WR |=> !NV_WR) else $error("writes too close");
	chk_byte_step: assert property (s_rec_byte |-> NV_ADDR == last_addr + 16'h0001)
		else $error("record byte not at next address");
	chk_marker_set: assert property (NV_WR && NV_ADDR[2:0] == 3'h0 |-> NV_WDATA[7])
		else $error("first byte lacks in-use marker");
	chk_sum_byte: assert property (NV_WR && NV_ADDR[2:0] == 3'h7 |-> NV_WDATA == sum)
		else $error("checksum byte wrong");
	chk_scan_base: assert property (NV_RD |-> NV_ADDR[2:0] == 3'h0)
		else $error("scan read off slot base");
endmodule
bind frl_logger frl_logger_chk #(.SLOTS(SLOTS)) u_frl_logger_chk (.CLOCK(CLOCK), .RST(RST),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .NV_ADDR(NV_ADDR),
	.NV_WDATA(NV_WDATA), .NV_WR(NV_WR), .NV_RD(NV_RD));

// [testbench/frl_nv_model.sv]
`timescale 1ns/1ps
module frl_nv_model (
	input  wire logic        CLOCK,
	input  wire logic        SLOW,
	input  wire logic [15:0] NV_ADDR,
	input  wire logic [7:0]  NV_WDATA,
	input  wire logic        NV_WR,
	input  wire logic        NV_RD,
	output logic      [7:0]  NV_RDATA,
	output logic             NV_BUSY
);
	logic [7:0] mem [128];
	// slot 0 finished, slot 1 torn with its marker clear
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[0] = 8'h80;
		mem[8] = 8'h13;
		NV_RDATA = 8'h00;
		NV_BUSY = 1'b0;
	end
	// data stand one cycle only; toggled after so stale bytes never match
	always @(posedge CLOCK) begin
		if (NV_WR) mem[NV_ADDR[6:0]] <= NV_WDATA;
		NV_RDATA <= NV_RD ? mem[NV_ADDR[6:0]] : ~NV_RDATA;
		NV_BUSY <= NV_WR & SLOW;
	end
endmodule

// [testbench/frl_logger_test.sv]
`timescale 1ns/1ps
module frl_logger_test
	import frl_pkg::*;
;
	typedef struct packed {logic [6:0] c; logic [5:0] p; logic [7:0] ec; logic [7:0] ep;} frl_row_s;
	frl_row_s   rows [8] = '{'{7'h40, 6'h3f, 8'h40, 8'h3f}, '{7'h20, 6'h01, 8'h20, 8'h01},
		'{7'h10, 6'h2a, 8'h10, 8'h2a}, '{7'h08, 6'h15, 8'h08, 8'h15}, '{7'h04, 6'h00, 8'h04, 8'h00},
		'{7'h02, 6'h3e, 8'h02, 8'h3e}, '{7'h01, 6'h07, 8'h01, 8'h07}, '{7'h7f, 6'h00, 8'h7f, 8'h00}};
	logic       clock = 1'b0, rst = 1'b1, seq_change = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       slow = 1'b0, nv_wr, nv_rd, nv_busy, log_busy, log_full;
	logic [5:0] new_st = 6'h00, prev_st = 6'h00;
	frl_cause_s cause = 7'h00;
	frl_flags_s flags = {10'h2a5, 10'h1c3, 10'h396, 5'h15};
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, nv_wdata, nv_rdata;
	logic [15:0] nv_addr;
	int         error_cnt = 0, n_compared = 0, cycles = 0;
	frl_logger #(.SLOTS(16), .STATES(64)) u_frl_logger (.CLOCK(clock), .RST(rst),
		.SEQ_CHANGE(seq_change), .SEQ_NEW_STATE(new_st), .SEQ_PREV_STATE(prev_st),
		.SEQ_CAUSE(cause), .LIVE_FLAGS(flags), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .NV_ADDR(nv_addr),
		.NV_WDATA(nv_wdata), .NV_WR(nv_wr), .NV_RD(nv_rd), .NV_RDATA(nv_rdata),
		.NV_BUSY(nv_busy), .LOG_BUSY(log_busy), .LOG_FULL(log_full));
	frl_nv_model u_frl_nv_model (.CLOCK(clock), .SLOW(slow), .NV_ADDR(nv_addr),
		.NV_WDATA(nv_wdata), .NV_WR(nv_wr), .NV_RD(nv_rd), .NV_RDATA(nv_rdata), .NV_BUSY(nv_busy));
	////////////////////////////////////////////////////////////////////////////////
	always #2 clock = ~clock;
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ceiling well above the couple of hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clock) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clock) reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, exp);
		@(posedge clock) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clock) reg_rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task seq(input logic [5:0] n, p, input logic [6:0] c);
		@(posedge clock) {seq_change, new_st, prev_st, cause} <= {1'b1, n, p, c};
		@(posedge clock) seq_change <= 1'b0;
	endtask
	// the global cycle ceiling bounds this wait
	task idle;
		repeat (3) @(posedge clock);
		while (log_busy !== 1'b0) @(posedge clock);
	endtask
	task rec(input int s, input logic [7:0] c, p);
		logic [7:0] b [8];
		b = '{c | 8'h80, p, flags.uv[7:0], {flags.ov[5:0], flags.uv[9:8]},
			{flags.gpi[3:0], flags.ov[9:6]}, flags.lim[7:0],
			{3'h0, flags.gpi[4], 2'h0, flags.lim[9:8]}, 8'h00};
		for (int i = 0; i < 7; i++) b[7] = b[7] + b[i];
		for (int i = 0; i < 8; i++) chk(u_frl_nv_model.mem[s * 8 + i], b[i]);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		idle();
		rd(8'h00, 8'h00);
		foreach (rows[i]) begin
			seq(6'h01, rows[i].p, rows[i].c);
			rd(FRL_CAUSE_OFS, rows[i].ec);
			rd(FRL_PREV_OFS, rows[i].ep);
			rd(FRL_SNAP1_OFS, flags.uv[7:0]);
		end
		// torn slot 1 must be reused, then slot 2 with the memory stalling
		wr(FRL_TRIG_OFS, 8'h20);
		seq(6'h05, 6'h09, 7'h08);
		idle();
		rec(1, 8'h08, 8'h09);
		slow <= 1'b1;
		seq(6'h05, 6'h05, 7'h44);
		idle();
		rec(2, 8'h44, 8'h05);
		seq(6'h06, 6'h05, 7'h01);
		idle();
		chk(u_frl_nv_model.mem[24], 8'h00);
		chk({7'h00, log_full}, 8'h00);
		rd(FRL_STATUS_OFS, 8'h00);
		test_done();
	end
endmodule
